// ---- lio_defines.svh ----
// Function
// - Writes accepted only in initialization mode
// - Lower frame byte holds the eight setting bits
// - Bit 7 set: over-voltage turns I/O-1 off
// - Bit 7 clear: I/O-1 ignores over-voltage
// - Second LIN select 00 off, 01 switch
// - Code 10 general I/O; 11 invalid
// - Bit 2 enables both I/O-1 drivers
// - Bit 1 enables both I/O-0 drivers
// - Cyclic sense: hold state, off between
`ifndef LIO_DEFINES_SVH
`define LIO_DEFINES_SVH

`define LIO_FRAME_BITS 5'h10
`define LIO_CNT_OVER 5'h11
`define LIO_REG_ADDR 5'h07
`define LIO_CMD_WRITE 2'h1
`define LIO_REG_RESET 8'h00
`define LIO_STATUS_BYTE 8'h00

`define LIO_CMD_HI 15
`define LIO_CMD_LO 14
`define LIO_ADDR_HI 13
`define LIO_ADDR_LO 9
`define LIO_B_OVOFF 7
`define LIO_F_LIN2_HI 6
`define LIO_F_LIN2_LO 5
`define LIO_F_LIN1_HI 4
`define LIO_F_LIN1_LO 3
`define LIO_B_IO1_EN 2
`define LIO_B_IO0_EN 1
`define LIO_B_CYC_INV 0

`define LIO_SEL_OFF 2'h0
`define LIO_SEL_SWITCH 2'h1
`define LIO_SEL_IO 2'h2
`define LIO_SEL_NA 2'h3

`define LIO_ST_IDLE 3'h1
`define LIO_ST_SHIFT 3'h2
`define LIO_ST_DONE 3'h4

`endif

// ---- lio_pkg.sv ----
`include "lio_defines.svh"

package lio_pkg;

    typedef enum logic [1:0] {
        LIO_PIN_OFF = `LIO_SEL_OFF,
        LIO_PIN_SWITCH = `LIO_SEL_SWITCH,
        LIO_PIN_IO = `LIO_SEL_IO,
        LIO_PIN_NA = `LIO_SEL_NA
    } lio_pin_mode_type;

    typedef enum logic [2:0] {
        LIO_IDLE = `LIO_ST_IDLE,
        LIO_SHIFT = `LIO_ST_SHIFT,
        LIO_DONE = `LIO_ST_DONE
    } lio_spi_state_type;

endpackage

// ---- lio_pin_sel.sv ----
`timescale 1ns/100ps
`include "lio_defines.svh"

module lio_pin_sel
    import lio_pkg::*;
(
    // Select field
    input wire logic [1:0] sel_in,
    // Decoded pin function
    output logic lin_switch_out,
    output logic io_mode_out,
    output logic invalid_out
);

    lio_pin_mode_type mode;

    always_comb begin
        mode = lio_pin_mode_type'(sel_in);
        lin_switch_out = 1'b0;
        io_mode_out = 1'b0;
        invalid_out = 1'b0;
        case (mode)
            LIO_PIN_OFF: begin
                lin_switch_out = 1'b0;
            end
            LIO_PIN_SWITCH: begin
                lin_switch_out = 1'b1;
            end
            LIO_PIN_IO: begin
                io_mode_out = 1'b1;
            end
            default: begin
                // Invalid code drives nothing rather than guessing a function
                invalid_out = 1'b1;
            end
        endcase
    end

endmodule

// ---- lio_setup.sv ----
`timescale 1ns/100ps
`include "lio_defines.svh"

module lio_setup
    import lio_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Serial port from the master
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    // Device mode and supervision
    input wire logic init_mode_in,
    input wire logic lp_mode_in,
    input wire logic cyc_sense_en_in,
    input wire logic cyc_sense_active_in,
    input wire logic ov_main_in,
    input wire logic ov_aux_in,
    // Driver requests from pin logic
    input wire logic io0_hs_req_in,
    input wire logic io0_ls_req_in,
    input wire logic io1_hs_req_in,
    input wire logic io1_ls_req_in,
    // Driver enables
    output logic io0_hs_en_out,
    output logic io0_ls_en_out,
    output logic io1_hs_en_out,
    output logic io1_ls_en_out,
    // LIN pin functions
    output logic lin1_switch_out,
    output logic lin1_io_out,
    output logic lin1_invalid_out,
    output logic lin2_switch_out,
    output logic lin2_io_out,
    output logic lin2_invalid_out,
    // Register view and status
    output logic [7:0] setup_reg_out,
    output logic write_refused_out
);

    lio_spi_state_type state, next_state;
    logic [15:0] rx, next_rx;
    logic [15:0] tx, next_tx;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic sclk_q, next_sclk_q;
    logic miso, next_miso;
    logic [7:0] setup, next_setup;
    logic refused, next_refused;
    logic lp_q, next_lp_q;
    logic held_hs, next_held_hs;
    logic held_ls, next_held_ls;
    logic sclk_rise, sclk_fall, frame_ok;

    assign sclk_rise = spi_sclk_in & ~sclk_q;
    assign sclk_fall = ~spi_sclk_in & sclk_q;
    // Exactly 16 clocks, write command, this register's address
    assign frame_ok = (bit_cnt == `LIO_FRAME_BITS)
        && (rx[`LIO_CMD_HI:`LIO_CMD_LO] == `LIO_CMD_WRITE)
        && (rx[`LIO_ADDR_HI:`LIO_ADDR_LO] == `LIO_REG_ADDR);

    // Serial frame handling and register update
    always_comb begin
        next_state = state;
        next_rx = rx;
        next_tx = tx;
        next_bit_cnt = bit_cnt;
        next_sclk_q = spi_sclk_in;
        next_miso = miso;
        next_setup = setup;
        next_refused = 1'b0;
        case (state)
            LIO_IDLE: begin
                if (!spi_cs_n_in) begin
                    next_state = LIO_SHIFT;
                    next_bit_cnt = 5'h00;
                    next_tx = {`LIO_STATUS_BYTE, setup};
                    // First bit out is the top of the status byte
                    next_miso = next_tx[15];
                end
            end
            LIO_SHIFT: begin
                if (spi_cs_n_in) begin
                    next_state = LIO_DONE;
                end else begin
                    if (sclk_rise) begin
                        next_rx = {rx[14:0], spi_mosi_in};
                        // Saturate so long frames stay rejected
                        if (bit_cnt != `LIO_CNT_OVER) begin
                            next_bit_cnt = bit_cnt + 5'h01;
                        end
                    end
                    if (sclk_fall) begin
                        next_tx = {tx[14:0], 1'b0};
                        next_miso = tx[14];
                    end
                end
            end
            LIO_DONE: begin
                next_state = LIO_IDLE;
                if (frame_ok) begin
                    if (init_mode_in) begin
                        next_setup = rx[7:0];
                    end else begin
                        next_refused = 1'b1;
                    end
                end
            end
            default: begin
                next_state = LIO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= LIO_IDLE;
            rx <= 16'h0000;
            tx <= 16'h0000;
            bit_cnt <= 5'h00;
            sclk_q <= 1'b0;
            miso <= 1'b0;
            setup <= `LIO_REG_RESET;
            refused <= 1'b0;
        end else begin
            state <= next_state;
            rx <= next_rx;
            tx <= next_tx;
            bit_cnt <= next_bit_cnt;
            sclk_q <= next_sclk_q;
            miso <= next_miso;
            setup <= next_setup;
            refused <= next_refused;
        end
    end

    // Snapshot of I/O-0 drive taken on low-power entry
    always_comb begin
        next_lp_q = lp_mode_in;
        next_held_hs = held_hs;
        next_held_ls = held_ls;
        if (lp_mode_in && !lp_q) begin
            next_held_hs = io0_hs_req_in;
            next_held_ls = io0_ls_req_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lp_q <= 1'b0;
            held_hs <= 1'b0;
            held_ls <= 1'b0;
        end else begin
            lp_q <= next_lp_q;
            held_hs <= next_held_hs;
            held_ls <= next_held_ls;
        end
    end

    logic io1_kill, cyc_on, io0_hs_raw, io0_ls_raw;

    // Over-voltage shutoff only when the setting asks for it
    assign io1_kill = setup[`LIO_B_OVOFF] & (ov_main_in | ov_aux_in);
    assign io1_hs_en_out = setup[`LIO_B_IO1_EN] & io1_hs_req_in & ~io1_kill;
    assign io1_ls_en_out = setup[`LIO_B_IO1_EN] & io1_ls_req_in & ~io1_kill;

    // Inverted policy swaps high and low side of the held state
    assign cyc_on = lp_q & cyc_sense_en_in;
    always_comb begin
        io0_hs_raw = io0_hs_req_in;
        io0_ls_raw = io0_ls_req_in;
        if (cyc_on) begin
            if (!cyc_sense_active_in) begin
                io0_hs_raw = 1'b0;
                io0_ls_raw = 1'b0;
            end else if (setup[`LIO_B_CYC_INV]) begin
                io0_hs_raw = held_ls;
                io0_ls_raw = held_hs;
            end else begin
                io0_hs_raw = held_hs;
                io0_ls_raw = held_ls;
            end
        end
    end
    assign io0_hs_en_out = setup[`LIO_B_IO0_EN] & io0_hs_raw;
    assign io0_ls_en_out = setup[`LIO_B_IO0_EN] & io0_ls_raw;

    lio_pin_sel u_lin1 (
        .sel_in(setup[`LIO_F_LIN1_HI:`LIO_F_LIN1_LO]),
        .lin_switch_out(lin1_switch_out),
        .io_mode_out(lin1_io_out),
        .invalid_out(lin1_invalid_out)
    );

    lio_pin_sel u_lin2 (
        .sel_in(setup[`LIO_F_LIN2_HI:`LIO_F_LIN2_LO]),
        .lin_switch_out(lin2_switch_out),
        .io_mode_out(lin2_io_out),
        .invalid_out(lin2_invalid_out)
    );

    assign spi_miso_out = miso;
    assign spi_miso_oe_out = (state == LIO_SHIFT);
    assign setup_reg_out = setup;
    assign write_refused_out = refused;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic wrote;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wrote <= 1'b0;
        end else if (state == LIO_DONE && frame_ok && init_mode_in) begin
            wrote <= 1'b1;
        end
    end

    sequence s_good_write;
        state == LIO_DONE && frame_ok && init_mode_in;
    endsequence

    sequence s_bad_write;
        state == LIO_DONE && frame_ok && !init_mode_in;
    endsequence

    // Next frame may already start one cycle after the commit
    a_write_commit: assert property (s_good_write |=> (state == LIO_IDLE)
        ##0 (setup == $past(rx[7:0])))
        else $error("setup write not stored");
    a_write_refuse: assert property (s_bad_write |=> $stable(setup) && write_refused_out)
        else $error("write outside init mode taken");
    a_ov_shutoff: assert property (setup[7] && (ov_main_in || ov_aux_in)
        |-> !io1_hs_en_out && !io1_ls_en_out)
        else $error("I/O-1 not off on over-voltage");
    a_ov_ignored: assert property (!setup[7] && setup[2] && io1_hs_req_in |-> io1_hs_en_out)
        else $error("I/O-1 dropped without shutoff setting");
    a_lin2_select: assert property (setup[6:5] == 2'h1 |-> lin2_switch_out && !lin2_io_out)
        else $error("second LIN switch mode wrong");
    a_lin2_io: assert property (setup[6:5] == 2'h2 |-> lin2_io_out && !lin2_switch_out)
        else $error("second LIN I/O mode wrong");
    a_io1_drv_off: assert property (!setup[2] |-> !io1_hs_en_out && !io1_ls_en_out)
        else $error("I/O-1 driver on while disabled");
    a_io0_drv_off: assert property (!setup[1] |-> !io0_hs_en_out && !io0_ls_en_out)
        else $error("I/O-0 driver on while disabled");
    a_cyc_off_time: assert property (lp_q && cyc_sense_en_in && !cyc_sense_active_in
        |-> !io0_hs_en_out && !io0_ls_en_out)
        else $error("I/O-0 driven in sense off time");
    a_reset_clear: assert property (!wrote |-> setup == 8'h00)
        else $error("setup nonzero before any write");

endmodule

// ---- lio_spi_master.sv ----
`timescale 1ns/100ps

module lio_spi_master (
    // Clock
    input wire logic clk_in,
    // Serial lines
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // Slow phases: the block sees each sclk edge through clk_in sampling
    task automatic frame(input logic [15:0] data, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            @(posedge clk_in);
            mosi_out <= data[15 - i];
            @(posedge clk_in);
            @(posedge clk_in);
            sclk_out <= 1'b1;
            rx = {rx[14:0], miso_in};
            @(posedge clk_in);
            @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        @(posedge clk_in);
        cs_n_out <= 1'b1;
        // Released line must not look like held data
        mosi_out <= ~mosi_out;
    endtask
endmodule

// ---- lio_setup_tb.sv ----
`timescale 1ns/100ps

module lio_setup_tb;
    logic clk_in, rst_n_in, sclk, cs_n, mosi, miso, miso_oe;
    logic init_mode, lp_mode, cyc_en, cyc_act, ov_main, ov_aux, refused;
    logic io0_hs, io0_ls, io1_hs, io1_ls;
    logic [3:0] req;
    logic [2:0] lin1, lin2;
    logic [7:0] setup, shadow;
    int error_cnt = 0;
    int total_checks = 0;
    wire logic [7:0] io0_v = {6'h00, io0_hs, io0_ls};
    wire logic [7:0] io1_v = {6'h00, io1_hs, io1_ls};

    lio_setup lio_setup_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
        .init_mode_in(init_mode), .lp_mode_in(lp_mode),
        .cyc_sense_en_in(cyc_en), .cyc_sense_active_in(cyc_act),
        .ov_main_in(ov_main), .ov_aux_in(ov_aux),
        .io0_hs_req_in(req[3]), .io0_ls_req_in(req[2]),
        .io1_hs_req_in(req[1]), .io1_ls_req_in(req[0]),
        .io0_hs_en_out(io0_hs), .io0_ls_en_out(io0_ls),
        .io1_hs_en_out(io1_hs), .io1_ls_en_out(io1_ls),
        .lin1_switch_out(lin1[2]), .lin1_io_out(lin1[1]), .lin1_invalid_out(lin1[0]),
        .lin2_switch_out(lin2[2]), .lin2_io_out(lin2[1]), .lin2_invalid_out(lin2[0]),
        .setup_reg_out(setup), .write_refused_out(refused)
    );

    lio_spi_master lio_spi_master_i (
        .clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi), .miso_in(miso)
    );

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Write frame; checks readback, refusal pulse and stored value
    task automatic wr(input logic [7:0] d, input logic [4:0] addr, input int n);
        logic [15:0] rx;
        logic seen;
        logic ok;
        seen = 1'b0;
        ok = (addr == 5'h07) && (n == 16);
        lio_spi_master_i.frame({2'h1, addr, 1'b0, d}, n, rx);
        if (n == 16) begin
            chk(rx[15:8], 8'h00);
            chk(rx[7:0], shadow);
        end
        for (int i = 0; i < 5; i++) begin
            @(negedge clk_in);
            seen = seen | refused;
            if (i < 2) begin
                chk({7'h00, miso_oe}, {7'h00, i == 0});
            end
        end
        chk({7'h00, seen}, {7'h00, ok & ~init_mode});
        if (ok && init_mode) begin
            shadow = d;
        end
        chk(setup, shadow);
    endtask

    task automatic t_por();
        @(negedge clk_in);
        chk(setup, 8'h00);
        chk(io0_v, 8'h00);
        chk(io1_v, 8'h00);
        chk({2'h0, lin1, lin2}, 8'h00);
        chk({7'h00, miso_oe}, 8'h00);
    endtask

    task automatic t_lin();
        logic [2:0] e;
        for (int c = 0; c < 4; c++) begin
            e = (c == 1) ? 3'h4 : (c == 2) ? 3'h2 : (c == 3) ? 3'h1 : 3'h0;
            wr({1'b0, c[1:0], c[1:0], 3'h0}, 5'h07, 16);
            chk({5'h00, lin2}, {5'h00, e});
            chk({5'h00, lin1}, {5'h00, e});
        end
    endtask

    task automatic t_refuse();
        wr(8'hA5, 5'h06, 16);
        wr(8'hA5, 5'h07, 15);
        @(posedge clk_in);
        init_mode <= 1'b0;
        wr(8'h5A, 5'h07, 16);
        @(posedge clk_in);
        init_mode <= 1'b1;
    endtask

    task automatic t_ov();
        wr(8'h84, 5'h07, 16);
        chk(io1_v, 8'h03);
        @(posedge clk_in);
        ov_main <= 1'b1;
        @(negedge clk_in);
        chk(io1_v, 8'h00);
        @(posedge clk_in);
        ov_main <= 1'b0;
        ov_aux <= 1'b1;
        @(negedge clk_in);
        chk(io1_v, 8'h00);
        wr(8'h04, 5'h07, 16);
        chk(io1_v, 8'h03);
        @(posedge clk_in);
        ov_aux <= 1'b0;
        wr(8'h02, 5'h07, 16);
        chk(io1_v, 8'h00);
        chk(io0_v, 8'h03);
    endtask

    // Snapshot is taken as low power starts, later requests must not leak
    // Second pass sets the policy bit: held high and low side swap
    task automatic t_cyc();
        for (int inv = 0; inv < 2; inv++) begin
            wr({7'h01, inv[0]}, 5'h07, 16);
            @(posedge clk_in);
            {cyc_en, cyc_act} <= 2'h3;
            req <= 4'hA;
            @(posedge clk_in);
            lp_mode <= 1'b1;
            repeat (3) @(posedge clk_in);
            req <= 4'h5;
            @(negedge clk_in);
            chk(io0_v, (inv == 0) ? 8'h02 : 8'h01);
            @(posedge clk_in);
            cyc_act <= 1'b0;
            @(negedge clk_in);
            chk(io0_v, 8'h00);
            @(posedge clk_in);
            {lp_mode, cyc_en} <= 2'h0;
            req <= 4'hF;
        end
    endtask

    task automatic t_rst();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        shadow = 8'h00;
        @(negedge clk_in);
        chk(setup, 8'h00);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        wr(8'h40, 5'h07, 16);
    endtask

    initial begin
        {rst_n_in, init_mode, lp_mode, cyc_en, cyc_act, ov_main, ov_aux} = 7'h20;
        req = 4'hF;
        shadow = 8'h00;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_por();
        t_lin();
        t_refuse();
        t_ov();
        t_cyc();
        t_rst();
        final_report();
    end
endmodule
